// [design/pwc_pkg.sv]
/*
  Package for the pwm generator with capture: register offsets, field
  positions, reset values and the AXI4-Lite carrier structs.
  Assumes a 32-bit AXI4-Lite master and a single 40 MHz clock.
*/
// Function
// - prescale then divide by 1,2,4,8,16
// - 16-bit period counter and duty comparator
// - zero sets period flag, enable gates request
// - dead zone: odd output complements even
// - period/duty buffered, loaded at counter end
// - auto-reload restarts counting from period, from zero in center type
// - one-shot stops at zero, one request
// - capture turns pin into input, same counter
// - rising/falling edges latch live counter
// - per-edge capture interrupt enables
// - capture interrupt reloads counter from period
// - write one clears indicator; input holds meanwhile
// - edge-aligned or center-aligned counting
// - edge type: high at duty, low after zero
// - edge widths: period-duty low, duty+1 high
// - center type: up, reverse, down, reload
// - center widths: 2(N-M)+1 low, 2M+1 high
// - center request at underflow or at peak
// - one-shot end clears period/duty, holds counter
// - one-shot restarts on nonzero period write
`default_nettype none
package pwc_pkg;
  // register byte offsets
  localparam logic [7:0] OffPsc    = 8'h00;
  localparam logic [7:0] OffDiv    = 8'h04;
  localparam logic [7:0] OffCtl    = 8'h08;
  localparam logic [7:0] OffDzEn   = 8'h0c;
  localparam logic [7:0] OffDzTime = 8'h10;
  localparam logic [7:0] OffIen    = 8'h14;
  localparam logic [7:0] OffInd    = 8'h18;
  localparam logic [7:0] OffPinEn  = 8'h1c;
  localparam logic [7:0] OffCcw    = 8'h20;
  localparam logic [7:0] OffCcwEnd = 8'h30;
  localparam logic [7:0] OffPer    = 8'h40;
  localparam logic [7:0] OffDut    = 8'h60;
  localparam logic [7:0] OffLive   = 8'h80;
  localparam logic [7:0] OffRise   = 8'ha0;
  localparam logic [7:0] OffFall   = 8'hc0;
  localparam logic [7:0] OffChEnd  = 8'he0;
  // field positions
  localparam int CtlSlot    = 4;
  localparam int CtlRunBit  = 0;
  localparam int CtlAutoBit = 1;
  localparam int CtlCtrBit  = 2;
  localparam int DivSlot    = 4;
  localparam int IenSelPos  = 16;
  localparam int IndCapPos  = 8;
  localparam int CcwHalf    = 16;
  localparam int CcwCapBit  = 0;
  localparam int CcwRiseBit = 1;
  localparam int CcwFallBit = 2;
  localparam int DzTimeW    = 8;
  localparam logic [2:0] DivMaxSel = 3'h4;
  // reset values and responses
  localparam logic [31:0] RstWord    = 32'h0;
  localparam logic [15:0] RstCnt     = 16'h0;
  localparam logic [1:0]  RespOkay   = 2'h0;
  localparam logic [1:0]  RespSlvErr = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } pwc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pwc_axi_rsp_s;
endpackage
`default_nettype wire

// [design/pwc_top.sv]
/*
  Eight-channel pwm generator with capture behind an AXI4-Lite slave.
  Assumes one clock (ref_clk), synchronous reset, asynchronous pins.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwc_top #(
  parameter int NumCh = 8,
  parameter int CntW  = 16,
  parameter int PscW  = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire pwc_pkg::pwc_axi_req_s axiReq,
  output var  pwc_pkg::pwc_axi_rsp_s axiRsp,
  input  wire logic [NumCh-1:0]     pinIn,
  output logic      [NumCh-1:0]     pinOut,
  output logic      [NumCh-1:0]     pinOe,
  output logic      [NumCh-1:0]     irqReq
);
  localparam int NumGen = NumCh / 2;

  logic awRdy_q, wRdy_q, bVal_q, arRdy_q, rVal_q;
  logic [1:0]  bResp_q, rResp_q;
  logic [31:0] aw_q, wd_q, rData_q, wMask, rdMux;
  logic [3:0]  ws_q;
  logic        doWr;
  logic [31:0] psc_q, div_q, ctl_q, dzEn_q, dzT_q, ien_q, pinEn_q;
  logic [31:0] ccw_q [4];
  logic [CntW-1:0] cnt_q [NumCh];
  logic [CntW-1:0] per_q [NumCh];
  logic [CntW-1:0] dut_q [NumCh];
  logic [CntW-1:0] bufPer_q [NumCh];
  logic [CntW-1:0] bufDut_q [NumCh];
  logic [CntW-1:0] riseL_q [NumCh];
  logic [CntW-1:0] fallL_q [NumCh];
  logic [NumCh-1:0]  perFlag_q, capFlag_q, rawOut;
  logic [NumGen-1:0] pTick, pairE, pairO;

  // address map check
  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) &&
             ((a[7:0] < pwc_pkg::OffCcwEnd) ||
              (a[7:0] >= pwc_pkg::OffPer && a[7:0] < pwc_pkg::OffChEnd));
  endfunction

  // byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign wMask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign doWr  = !awRdy_q && !wRdy_q && !bVal_q;

  // response struct straight from flops
  assign axiRsp.awready = awRdy_q;
  assign axiRsp.wready  = wRdy_q;
  assign axiRsp.bvalid  = bVal_q;
  assign axiRsp.bresp   = bResp_q;
  assign axiRsp.arready = arRdy_q;
  assign axiRsp.rvalid  = rVal_q;
  assign axiRsp.rdata   = rData_q;
  assign axiRsp.rresp   = rResp_q;

  // write channels: address and data taken in either order
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      awRdy_q <= 1'b1;
      wRdy_q  <= 1'b1;
      bVal_q  <= 1'b0;
      bResp_q <= pwc_pkg::RespOkay;
      aw_q    <= pwc_pkg::RstWord;
      wd_q    <= pwc_pkg::RstWord;
      ws_q    <= 4'h0;
    end
    else
    begin
      if (axiReq.awvalid && awRdy_q)
      begin
        aw_q    <= axiReq.awaddr;
        awRdy_q <= 1'b0;
      end
      if (axiReq.wvalid && wRdy_q)
      begin
        wd_q   <= axiReq.wdata;
        ws_q   <= axiReq.wstrb;
        wRdy_q <= 1'b0;
      end
      if (doWr)
      begin
        bVal_q  <= 1'b1;
        bResp_q <= mapped(aw_q) ? pwc_pkg::RespOkay : pwc_pkg::RespSlvErr;
      end
      if (bVal_q && axiReq.bready)
      begin
        bVal_q  <= 1'b0;
        awRdy_q <= 1'b1;
        wRdy_q  <= 1'b1;
      end
    end
  end

  // read decode
  always_comb
  begin
    logic [7:0] a;
    logic [2:0] i;
    a = axiReq.araddr[7:0];
    i = axiReq.araddr[4:2];
    rdMux = pwc_pkg::RstWord;
    if (!mapped(axiReq.araddr))
      rdMux = pwc_pkg::RstWord;
    else if (a == pwc_pkg::OffPsc)
      rdMux = psc_q;
    else if (a == pwc_pkg::OffDiv)
      rdMux = div_q;
    else if (a == pwc_pkg::OffCtl)
      rdMux = ctl_q;
    else if (a == pwc_pkg::OffDzEn)
      rdMux = dzEn_q;
    else if (a == pwc_pkg::OffDzTime)
      rdMux = dzT_q;
    else if (a == pwc_pkg::OffIen)
      rdMux = ien_q;
    else if (a == pwc_pkg::OffInd)
      rdMux = {16'h0, capFlag_q, perFlag_q};
    else if (a == pwc_pkg::OffPinEn)
      rdMux = pinEn_q;
    else if (a[7:4] == pwc_pkg::OffCcw[7:4])
      rdMux = ccw_q[a[3:2]];
    else if (a[7:5] == pwc_pkg::OffPer[7:5])
      rdMux = {16'h0, bufPer_q[i]};
    else if (a[7:5] == pwc_pkg::OffDut[7:5])
      rdMux = {16'h0, bufDut_q[i]};
    else if (a[7:5] == pwc_pkg::OffLive[7:5])
      rdMux = {16'h0, cnt_q[i]};
    else if (a[7:5] == pwc_pkg::OffRise[7:5])
      rdMux = {16'h0, riseL_q[i]};
    else
      rdMux = {16'h0, fallL_q[i]};
  end

  // read channel: one cycle from address to data
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      arRdy_q <= 1'b1;
      rVal_q  <= 1'b0;
      rData_q <= pwc_pkg::RstWord;
      rResp_q <= pwc_pkg::RespOkay;
    end
    else if (axiReq.arvalid && arRdy_q)
    begin
      arRdy_q <= 1'b0;
      rVal_q  <= 1'b1;
      rData_q <= rdMux;
      rResp_q <= mapped(axiReq.araddr) ? pwc_pkg::RespOkay : pwc_pkg::RespSlvErr;
    end
    else if (rVal_q && axiReq.rready)
    begin
      rVal_q  <= 1'b0;
      arRdy_q <= 1'b1;
    end
  end

  // shared configuration registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      psc_q  <= pwc_pkg::RstWord;
      div_q  <= pwc_pkg::RstWord;
      ctl_q  <= pwc_pkg::RstWord;
      dzEn_q <= pwc_pkg::RstWord;
      dzT_q  <= pwc_pkg::RstWord;
      ien_q  <= pwc_pkg::RstWord;
      pinEn_q <= pwc_pkg::RstWord;
      for (int k = 0; k < 4; k++)
        ccw_q[k] <= pwc_pkg::RstWord;
    end
    else if (doWr && mapped(aw_q))
    begin
      if (aw_q[7:0] == pwc_pkg::OffPsc)
        psc_q <= merge(psc_q, wd_q, wMask);
      else if (aw_q[7:0] == pwc_pkg::OffDiv)
        div_q <= merge(div_q, wd_q, wMask);
      else if (aw_q[7:0] == pwc_pkg::OffCtl)
        ctl_q <= merge(ctl_q, wd_q, wMask);
      else if (aw_q[7:0] == pwc_pkg::OffDzEn)
        dzEn_q <= merge(dzEn_q, wd_q, wMask);
      else if (aw_q[7:0] == pwc_pkg::OffDzTime)
        dzT_q <= merge(dzT_q, wd_q, wMask);
      else if (aw_q[7:0] == pwc_pkg::OffIen)
        ien_q <= merge(ien_q, wd_q, wMask);
      else if (aw_q[7:0] == pwc_pkg::OffPinEn)
        pinEn_q <= merge(pinEn_q, wd_q, wMask);
      else if (aw_q[31:4] == {24'h0, pwc_pkg::OffCcw[7:4]})
        ccw_q[aw_q[3:2]] <= merge(ccw_q[aw_q[3:2]], wd_q, wMask);
    end
  end

  // per-generator prescaler and dead-zone pair
  for (genvar g = 0; g < NumGen; g++)
  begin : gen_pair
    logic [PscW-1:0]    pscCnt_q;
    logic [pwc_pkg::DzTimeW-1:0] dzCnt_q;
    logic               prev_q;
    logic               settled;
    assign pTick[g] = pscCnt_q == psc_q[g*PscW +: PscW];
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst || pTick[g])
        pscCnt_q <= '0;
      else
        pscCnt_q <= pscCnt_q + 1'b1;
    end
    // dead time counts ref_clk cycles after each edge of the even output
    assign settled = (dzCnt_q == dzT_q[g*pwc_pkg::DzTimeW +: pwc_pkg::DzTimeW]) &&
                     (prev_q == rawOut[2*g]);
    assign pairE[g] = rawOut[2*g] && settled;
    assign pairO[g] = !rawOut[2*g] && settled;
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        dzCnt_q <= '0;
        prev_q  <= 1'b0;
      end
      else
      begin
        prev_q <= rawOut[2*g];
        if (prev_q != rawOut[2*g])
          dzCnt_q <= '0;
        else if (!settled)
          dzCnt_q <= dzCnt_q + 1'b1;
      end
    end
  end

  // per-channel timer, capture and flags
  for (genvar c = 0; c < NumCh; c++)
  begin : gen_ch
    logic [3:0] divCnt_q, mask;
    logic [2:0] sel;
    logic run, auto, ctr, capEn, tick, zeroPt, perEv, osEnd, capRl;
    logic up_q, st_q, done_q, s1_q, s2_q, s3_q, rise, fall, perWr, dutWr;
    logic [31:0] ccw;
    assign ccw   = ccw_q[c/2] >> (pwc_pkg::CcwHalf * (c % 2));
    assign run   = ctl_q[pwc_pkg::CtlSlot*c + pwc_pkg::CtlRunBit];
    assign auto  = ctl_q[pwc_pkg::CtlSlot*c + pwc_pkg::CtlAutoBit];
    assign ctr   = ctl_q[pwc_pkg::CtlSlot*c + pwc_pkg::CtlCtrBit];
    assign capEn = ccw[pwc_pkg::CcwCapBit];
    assign sel   = (div_q[pwc_pkg::DivSlot*c +: 3] > pwc_pkg::DivMaxSel) ?
                   pwc_pkg::DivMaxSel : div_q[pwc_pkg::DivSlot*c +: 3];
    assign mask  = 4'((5'h1 << sel) - 5'h1);
    assign tick  = pTick[c/2] && ((divCnt_q & mask) == mask);
    assign perWr = doWr && aw_q[31:5] == {24'h0, pwc_pkg::OffPer[7:5]} &&
                   aw_q[4:0] == {3'(c), 2'h0};
    assign dutWr = doWr && aw_q[31:5] == {24'h0, pwc_pkg::OffDut[7:5]} &&
                   aw_q[4:0] == {3'(c), 2'h0};
    // end of period: zero in edge type, underflow in center type
    assign zeroPt = ctr ? (!up_q && cnt_q[c] == '0) : (cnt_q[c] == '0);
    assign perEv  = run && tick && st_q && !done_q && !capRl &&
                    ((ctr && ien_q[pwc_pkg::IenSelPos + c]) ?
                     (up_q && cnt_q[c] >= per_q[c]) : zeroPt);
    assign osEnd  = run && tick && st_q && !done_q && !capRl && zeroPt && !auto;
    // output: high while counter below duty
    // edge type and center down-count include the duty value itself
    assign rawOut[c] = st_q && ((ctr && up_q) ? cnt_q[c] < dut_q[c]
                                              : cnt_q[c] <= dut_q[c]);

    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
        divCnt_q <= 4'h0;
      else if (pTick[c/2])
        divCnt_q <= divCnt_q + 4'h1;
    end

    // software buffers, cleared when a one-shot completes
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        bufPer_q[c] <= pwc_pkg::RstCnt;
        bufDut_q[c] <= pwc_pkg::RstCnt;
      end
      else
      begin
        if (osEnd)
        begin
          bufPer_q[c] <= pwc_pkg::RstCnt;
          bufDut_q[c] <= pwc_pkg::RstCnt;
        end
        if (perWr)
          bufPer_q[c] <= 16'(merge({16'h0, bufPer_q[c]}, wd_q, wMask));
        if (dutWr)
          bufDut_q[c] <= 16'(merge({16'h0, bufDut_q[c]}, wd_q, wMask));
      end
    end

    // counter: edge type counts down, center type up then down
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst || !run)
      begin
        cnt_q[c] <= pwc_pkg::RstCnt;
        per_q[c] <= pwc_pkg::RstCnt;
        dut_q[c] <= pwc_pkg::RstCnt;
        up_q     <= 1'b1;
        st_q     <= 1'b0;
        done_q   <= 1'b0;
      end
      else if (perWr && !auto && (wd_q[15:0] & wMask[15:0]) != 16'h0)
      begin
        done_q <= 1'b0;
        st_q   <= 1'b0;
      end
      else if (capRl)
        cnt_q[c] <= bufPer_q[c];
      else if (tick && !done_q)
      begin
        if (!st_q || zeroPt)
        begin
          per_q[c] <= bufPer_q[c];
          dut_q[c] <= bufDut_q[c];
          cnt_q[c] <= ctr ? pwc_pkg::RstCnt : bufPer_q[c];
          st_q     <= 1'b1;
          up_q     <= 1'b1;
          if (st_q && !auto)
          begin
            done_q   <= 1'b1;
            cnt_q[c] <= pwc_pkg::RstCnt;
          end
        end
        else if (ctr && up_q)
        begin
          if (cnt_q[c] >= per_q[c])
            up_q <= 1'b0;
          else
            cnt_q[c] <= cnt_q[c] + 16'h1;
        end
        else
          cnt_q[c] <= cnt_q[c] - 16'h1;
      end
    end

    // capture input: two-flop sync then edge detect
    assign rise  = capEn && s2_q && !s3_q;
    assign fall  = capEn && !s2_q && s3_q;
    assign capRl = (rise && ccw[pwc_pkg::CcwRiseBit]) ||
                   (fall && ccw[pwc_pkg::CcwFallBit]);
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        s1_q       <= 1'b0;
        s2_q       <= 1'b0;
        s3_q       <= 1'b0;
        riseL_q[c] <= pwc_pkg::RstCnt;
        fallL_q[c] <= pwc_pkg::RstCnt;
      end
      else
      begin
        s1_q <= pinIn[c];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (rise)
          riseL_q[c] <= cnt_q[c];
        if (fall)
          fallL_q[c] <= cnt_q[c];
      end
    end

    // sticky flags, write one clears, a new event wins
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        perFlag_q[c] <= 1'b0;
        capFlag_q[c] <= 1'b0;
      end
      else
      begin
        if (perEv)
          perFlag_q[c] <= 1'b1;
        else if (doWr && aw_q == {24'h0, pwc_pkg::OffInd} && wd_q[c] && ws_q[0])
          perFlag_q[c] <= 1'b0;
        if (capRl)
          capFlag_q[c] <= 1'b1;
        else if (doWr && aw_q == {24'h0, pwc_pkg::OffInd} &&
                 wd_q[pwc_pkg::IndCapPos + c] && ws_q[1])
          capFlag_q[c] <= 1'b0;
      end
    end

    // pins and request, all registered
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        pinOut[c] <= 1'b0;
        pinOe[c]  <= 1'b0;
        irqReq[c] <= 1'b0;
      end
      else
      begin
        pinOut[c] <= dzEn_q[c/2] ? ((c % 2 == 0) ? pairE[c/2] : pairO[c/2])
                                 : rawOut[c];
        pinOe[c]  <= pinEn_q[c] && !capEn;
        irqReq[c] <= (perFlag_q[c] && ien_q[c]) || capFlag_q[c];
      end
    end
  end
endmodule // pwc_top
`default_nettype wire

// [verif/pwc_props.sv]
/*
  Port-level checker for the pwm generator with capture.
  Assumes the pwc_top ports and a single ref_clk domain with sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pwc_props #(
  parameter int NumCh = 8
) (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire pwc_pkg::pwc_axi_req_s axiReq,
  input wire pwc_pkg::pwc_axi_rsp_s axiRsp,
  input wire logic [NumCh-1:0]      pinIn,
  input wire logic [NumCh-1:0]      pinOut,
  input wire logic [NumCh-1:0]      pinOe,
  input wire logic [NumCh-1:0]      irqReq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // outputs quiet right after reset release
  rst_quiet_a: assert property ($fell(sys_rst) |-> pinOut == '0 && irqReq == '0)
    else $error("pins or requests active after reset");
  // write answered two cycles after both halves taken
  wr_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##2 axiRsp.bvalid) else $error("write response late");
  // write response drops after its handshake
  b_release_a: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
    else $error("write response held too long");
  // no new write taken while a response is pending
  wr_block_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted during response");
  // read answered one cycle after address taken
  rd_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read response late");
  // read data drops after its handshake
  r_release_a: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
    else $error("read response held too long");
  // no new read taken while data is pending
  rd_block_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read accepted during response");
  // reads at 0xe0 and above give an error and zero data
  unmapped_err_a: assert property (axiReq.arvalid && axiRsp.arready
    && axiReq.araddr >= 32'he0 |=> axiRsp.rresp == pwc_pkg::RespSlvErr && axiRsp.rdata == '0)
    else $error("unmapped read not refused");
endmodule // pwc_props

bind pwc_top pwc_props #(.NumCh(NumCh)) i_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
`default_nettype wire

// [verif/pwc_pin_model.sv]
/*
  Pin-side partner: power stage load and capture signal source.
  Assumes the bench sets source levels just after a rising ref_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pwc_pin_model #(
  parameter int NumCh = 8
) (
  input  wire logic [NumCh-1:0] pinOut,
  input  wire logic [NumCh-1:0] pinOe,
  output logic      [NumCh-1:0] pinIn
);
  logic [NumCh-1:0] srcLvl;

  initial srcLvl = '0;

  // pin level: device drives where enabled, the source elsewhere
  assign pinIn = (pinOe & pinOut) | (~pinOe & srcLvl);

  // capture source level change, called after a rising edge
  task automatic set_level(input int ch, input logic lvl);
    srcLvl[ch] <= lvl;
  endtask
endmodule // pwc_pin_model
`default_nettype wire

// [verif/pwc_top_bench.sv]
/*
  Self-checking bench for the pwm generator with capture.
  Assumes pwc_top, pwc_pin_model and the bound checker; 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pwc_top_bench;
  logic                  ref_clk;
  logic                  sys_rst;
  pwc_pkg::pwc_axi_req_s axiReq;
  pwc_pkg::pwc_axi_rsp_s axiRsp;
  logic [7:0]            pinIn;
  logic [7:0]            pinOut;
  logic [7:0]            pinOe;
  logic [7:0]            irqReq;
  logic [31:0]           rd;
  logic [1:0]            rsp;
  int                    miscompares;
  int                    nCompared;
  int                    hi;
  int                    lo;

  // free-running clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  pwc_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
  pwc_pin_model i_pins (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write, both halves offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    axiReq.awaddr <= {24'h0, a};
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid)
      begin
        rsp = axiRsp.bresp;
        break;
      end
    end
    if (n == 50)
    begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    axiReq.araddr <= {24'h0, a};
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid)
      begin
        rd = axiRsp.rdata;
        rsp = axiRsp.rresp;
        break;
      end
    end
    if (n == 50)
    begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask

  // bounded wait for a rising level on a request or pin
  task automatic wait_rise(input logic sel_irq, input int ch);
    int n;
    logic prev;
    prev = 1'b1;
    for (n = 0; n < 2000; n++)
    begin
      @(posedge ref_clk);
      if (!prev && (sel_irq ? irqReq[ch] : pinOut[ch])) break;
      prev = sel_irq ? irqReq[ch] : pinOut[ch];
    end
    if (n == 2000)
    begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask

  // high then low width of one output cycle, in ref_clk cycles
  task automatic measure(input int ch);
    int n;
    hi = 0;
    lo = 0;
    wait_rise(1'b0, ch);
    for (n = 0; n < 2000 && pinOut[ch]; n++)
    begin
      @(posedge ref_clk);
      hi++;
    end
    for (n = 0; n < 2000 && !pinOut[ch]; n++)
    begin
      @(posedge ref_clk);
      lo++;
    end
    if (hi == 2000 || lo == 2000)
    begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask

  task automatic test_regs;
    axi_rd(pwc_pkg::OffPer);
    chk(rd, 32'h0);
    axi_rd(8'hfc);
    chk({30'h0, rsp}, {30'h0, pwc_pkg::RespSlvErr});
    axi_wr(pwc_pkg::OffRise, 32'h1234);
    axi_rd(pwc_pkg::OffRise);
    chk(rd, 32'h0);
    $display("register test done");
  endtask

  task automatic test_edge;
    axi_wr(pwc_pkg::OffPsc, 32'h1);
    axi_wr(pwc_pkg::OffDiv, 32'h1);
    axi_wr(pwc_pkg::OffDut, 32'h2);
    axi_wr(pwc_pkg::OffPer, 32'h6);
    axi_wr(pwc_pkg::OffPinEn, 32'h1);
    axi_wr(pwc_pkg::OffCtl, 32'h3);
    measure(0);
    chk(hi, 12);
    chk(lo, 16);
    axi_wr(pwc_pkg::OffDut, 32'h4);
    measure(0);
    measure(0);
    chk(hi, 20);
    chk(lo, 8);
    axi_wr(pwc_pkg::OffDut, 32'h6);
    repeat (80) @(posedge ref_clk);
    lo = 0;
    repeat (60)
    begin
      @(posedge ref_clk);
      if (!pinOut[0]) lo++;
    end
    chk(lo, 0);
    $display("edge-aligned test done");
  endtask

  task automatic test_center;
    axi_wr(pwc_pkg::OffDut + 8'h8, 32'h1);
    axi_wr(pwc_pkg::OffPer + 8'h8, 32'h4);
    axi_wr(pwc_pkg::OffPinEn, 32'h4);
    axi_wr(pwc_pkg::OffCtl, 32'h700);
    measure(2); // first pulse after start is partial
    measure(2);
    chk(hi, 3);
    chk(lo, 7);
    for (int s = 0; s < 2; s++)
    begin
      axi_wr(pwc_pkg::OffIen, {13'h0, s[0], 18'h4});
      axi_wr(pwc_pkg::OffInd, 32'h4);
      wait_rise(1'b1, 2);
      chk(pinOut[2], s == 0);
    end
    $display("center-aligned test done");
  endtask

  task automatic test_oneshot;
    axi_wr(pwc_pkg::OffCtl, 32'h0);
    axi_wr(pwc_pkg::OffDut + 8'h4, 32'h1);
    axi_wr(pwc_pkg::OffPer + 8'h4, 32'h3);
    axi_wr(pwc_pkg::OffIen, 32'h2);
    axi_wr(pwc_pkg::OffCtl, 32'h10);
    wait_rise(1'b1, 1);
    axi_rd(pwc_pkg::OffInd);
    chk(rd[1], 1'b1);
    axi_rd(pwc_pkg::OffPer + 8'h4);
    chk(rd, 32'h0);
    axi_rd(pwc_pkg::OffDut + 8'h4);
    chk(rd, 32'h0);
    axi_wr(pwc_pkg::OffInd, 32'h2);
    repeat (40) @(posedge ref_clk);
    chk(irqReq[1], 1'b0);
    axi_wr(pwc_pkg::OffDut + 8'h4, 32'h1);
    axi_wr(pwc_pkg::OffPer + 8'h4, 32'h3);
    wait_rise(1'b1, 1);
    axi_wr(pwc_pkg::OffInd, 32'h2);
    $display("one-shot test done");
  endtask

  task automatic test_capture;
    axi_wr(pwc_pkg::OffPer + 8'hc, 32'h64);
    axi_wr(pwc_pkg::OffCcw + 8'h4, 32'h0003_0000);
    axi_wr(pwc_pkg::OffPinEn, 32'h8);
    axi_wr(pwc_pkg::OffCtl, 32'h3000);
    repeat (10) @(posedge ref_clk);
    chk(pinOe[3], 1'b0);
    i_pins.set_level(3, 1'b1);
    repeat (20) @(posedge ref_clk);
    i_pins.set_level(3, 1'b0);
    repeat (6) @(posedge ref_clk);
    chk(irqReq[3], 1'b1);
    axi_rd(pwc_pkg::OffInd);
    chk(rd[11], 1'b1);
    axi_rd(pwc_pkg::OffFall + 8'hc);
    chk(rd >= 32'd78 && rd <= 32'd82, 1'b1);
    axi_wr(pwc_pkg::OffInd, 32'h800);
    repeat (3) @(posedge ref_clk);
    chk(irqReq[3], 1'b0);
    $display("capture test done");
  endtask

  task automatic test_dead;
    axi_wr(pwc_pkg::OffDut, 32'h2);
    axi_wr(pwc_pkg::OffDzTime, 32'h2);
    axi_wr(pwc_pkg::OffDzEn, 32'h1);
    axi_wr(pwc_pkg::OffPinEn, 32'h3);
    axi_wr(pwc_pkg::OffCtl, 32'h3);
    hi = 0;
    lo = 0;
    repeat (200)
    begin
      @(posedge ref_clk);
      if (pinOut[0] && pinOut[1]) hi++;
      if (pinOut[1]) lo++;
    end
    chk(hi, 0);
    chk(lo > 0, 1'b1);
    $display("dead-zone test done");
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    axiReq = '0;
    sys_rst = 1'b1;
    miscompares = 0;
    nCompared = 0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    test_regs();
    test_edge();
    test_center();
    test_oneshot();
    test_capture();
    test_dead();
    wrap_up();
  end
endmodule // pwc_top_bench
`default_nettype wire
